// >>> pbo_core.sv
// black level offset and bit shift pixel path with register port and output fifo
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module pbo_core
  import pbo_pkg::*;
#(
  parameter int DEPTH = PBO_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [PBO_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pixel input
  input wire logic pix_valid,
  input wire logic [PBO_SW-1:0] pix_data,
  input wire logic [1:0] pix_tap,
  input wire logic pix_sol,
  input wire logic pix_eol,
  output logic pix_ready,
  // pixel output
  output logic out_valid,
  output logic [PBO_SW-1:0] out_data,
  output logic out_eol,
  input wire logic out_ready
);
  localparam int LW = $clog2(DEPTH+1);
  localparam int FW = PBO_SW + 1;

  generate
    if (DEPTH < 4) begin : g_chk
      $error("pbo_core needs a fifo DEPTH of at least 4");
    end
  endgenerate

  function automatic logic [PBO_BLW-1:0] tap_off(input logic [PBO_BLW-1:0] bl [4], input logic [1:0] tap);
    case (tap)
      PBO_TAP_RED: tap_off = bl[PBO_SEL_RED];
      PBO_TAP_GREEN: tap_off = bl[PBO_SEL_GREEN];
      PBO_TAP_BLUE: tap_off = bl[PBO_SEL_BLUE];
      default: tap_off = '0;
    endcase
  endfunction : tap_off

  ////////////////////////////////////////////////////////////////////////////
  // software settings

  logic [1:0] sel_r, sel_nxt;
  logic [PBO_BLW-1:0] bl_r [4];
  logic [PBO_BLW-1:0] bl_nxt [4];
  logic [2:0] shift_r, shift_nxt;
  logic fmt_r, fmt_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic sat_r, sat_nxt;
  logic shp_sat, s1_wr;
  logic fifo_full;
  pbo_state_e st_r, st_nxt;

  always_comb begin
    sel_nxt = sel_r;
    bl_nxt = bl_r;
    shift_nxt = shift_r;
    fmt_nxt = fmt_r;
    if (reg_wr) begin
      case (reg_addr)
        PBO_REG_SEL: sel_nxt = reg_wdata[1:0];
        PBO_REG_VAL: bl_nxt[sel_r] = reg_wdata;
        PBO_REG_SHIFT: begin
          // codes above four are refused and the old shift stays
          if (reg_wdata <= {5'h00, PBO_SHIFT_MAX}) begin
            shift_nxt = reg_wdata[2:0];
          end
        end
        PBO_REG_FMT: fmt_nxt = reg_wdata[0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        PBO_REG_SEL: rdata_nxt = {6'h00, sel_r};
        PBO_REG_VAL: rdata_nxt = bl_r[sel_r];
        PBO_REG_SHIFT: rdata_nxt = {5'h00, shift_r};
        PBO_REG_FMT: rdata_nxt = {7'h00, fmt_r};
        PBO_REG_STAT: begin
          rdata_nxt[PBO_STAT_LINE] = (st_r == PBO_ST_LINE);
          rdata_nxt[PBO_STAT_SAT] = sat_r;
          rdata_nxt[PBO_STAT_FULL] = fifo_full;
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
    // a saturation in the same cycle as the clearing read survives
    sat_nxt = (sat_r & ~(reg_rd & (reg_addr == PBO_REG_STAT))) | (s1_wr & shp_sat);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_r <= PBO_SEL_ALL;
      for (int i = 0; i < 4; i++) begin
        bl_r[i] <= PBO_BL_RST;
      end
      shift_r <= PBO_SHIFT_RST;
      fmt_r <= PBO_FMT_RST;
      rdata_r <= 8'h00;
      sat_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      bl_r <= bl_nxt;
      shift_r <= shift_nxt;
      fmt_r <= fmt_nxt;
      rdata_r <= rdata_nxt;
      sat_r <= sat_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // line tracking and active settings

  logic fire, load;
  logic [PBO_BLW-1:0] act_bl_r [4];
  logic [PBO_BLW-1:0] act_bl_nxt [4];
  logic [PBO_BLW-1:0] use_bl [4];
  logic [2:0] act_shift_r, act_shift_nxt;
  logic act_fmt_r, act_fmt_nxt;
  logic pix_ready_r, pix_ready_nxt;

  assign fire = pix_valid & pix_ready_r;
  assign load = fire & pix_sol;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      PBO_ST_IDLE: if (load && !pix_eol) st_nxt = PBO_ST_LINE;
      PBO_ST_LINE: if (fire && pix_eol) st_nxt = PBO_ST_IDLE;
      default: st_nxt = PBO_ST_IDLE;
    endcase
    // settings written mid-line wait for the next line start
    act_bl_nxt = load ? bl_r : act_bl_r;
    act_shift_nxt = load ? shift_r : act_shift_r;
    act_fmt_nxt = load ? fmt_r : act_fmt_r;
    use_bl = act_bl_nxt;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= PBO_ST_IDLE;
      for (int i = 0; i < 4; i++) begin
        act_bl_r[i] <= PBO_BL_RST;
      end
      act_shift_r <= PBO_SHIFT_RST;
      act_fmt_r <= PBO_FMT_RST;
    end else begin
      st_r <= st_nxt;
      act_bl_r <= act_bl_nxt;
      act_shift_r <= act_shift_nxt;
      act_fmt_r <= act_fmt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // offset stage

  logic [8:0] blk;
  logic [PBO_SW:0] sum;
  logic [PBO_SW-1:0] clamped;
  logic s1_valid_r, s1_valid_nxt;
  logic [PBO_SW-1:0] s1_data_r, s1_data_nxt;
  logic s1_eol_r, s1_eol_nxt;
  logic [2:0] s1_shift_r, s1_shift_nxt;
  logic s1_fmt_r, s1_fmt_nxt;
  logic fifo_wr_ready;
  logic [LW-1:0] fifo_level;
  logic [LW+1:0] commit;

  always_comb begin
    blk = {1'b0, use_bl[PBO_SEL_ALL]} + {1'b0, tap_off(use_bl, pix_tap)};
    // offset lands in sample lsbs, so 8 bit depth at shift 0 sees it divided by 16
    sum = {1'b0, pix_data} + {4'h0, blk};
    clamped = sum[PBO_SW] ? PBO_FULL : sum[PBO_SW-1:0];
    s1_valid_nxt = s1_valid_r & ~fifo_wr_ready;
    s1_data_nxt = s1_data_r;
    s1_eol_nxt = s1_eol_r;
    s1_shift_nxt = s1_shift_r;
    s1_fmt_nxt = s1_fmt_r;
    if (fire) begin
      s1_valid_nxt = 1'b1;
      s1_data_nxt = clamped;
      s1_eol_nxt = pix_eol;
      s1_shift_nxt = act_shift_nxt;
      s1_fmt_nxt = act_fmt_nxt;
    end
    // ready is registered, so leave room for the stage and one more pixel
    commit = (LW+2)'(fifo_level) + (LW+2)'(s1_valid_r) + (LW+2)'(fire);
    pix_ready_nxt = commit < (LW+2)'(DEPTH-1);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_valid_r <= 1'b0;
      s1_data_r <= '0;
      s1_eol_r <= 1'b0;
      s1_shift_r <= PBO_SHIFT_RST;
      s1_fmt_r <= PBO_FMT_RST;
      pix_ready_r <= 1'b0;
    end else begin
      s1_valid_r <= s1_valid_nxt;
      s1_data_r <= s1_data_nxt;
      s1_eol_r <= s1_eol_nxt;
      s1_shift_r <= s1_shift_nxt;
      s1_fmt_r <= s1_fmt_nxt;
      pix_ready_r <= pix_ready_nxt;
    end
  end

  assign pix_ready = pix_ready_r;

  ////////////////////////////////////////////////////////////////////////////
  // shift, fifo and output register

  logic [PBO_SW-1:0] shp_data;
  logic [FW-1:0] fifo_rdata;
  logic fifo_rd_valid, take;
  logic out_valid_r, out_valid_nxt;
  logic [PBO_SW-1:0] out_data_r, out_data_nxt;
  logic out_eol_r, out_eol_nxt;

  assign s1_wr = s1_valid_r & fifo_wr_ready;
  assign fifo_full = ~fifo_wr_ready;

  pbo_shift u_shift (
    .sample(s1_data_r),
    .shift(s1_shift_r),
    .fmt12(s1_fmt_r),
    .result(shp_data),
    .sat(shp_sat)
  );

  pbo_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .wr_valid(s1_valid_r),
    .wr_ready(fifo_wr_ready),
    .wr_data({s1_eol_r, shp_data}),
    .rd_valid(fifo_rd_valid),
    .rd_ready(take),
    .rd_data(fifo_rdata),
    .level(fifo_level)
  );

  assign take = ~out_valid_r | out_ready;

  always_comb begin
    out_valid_nxt = out_valid_r;
    out_data_nxt = out_data_r;
    out_eol_nxt = out_eol_r;
    if (take) begin
      out_valid_nxt = fifo_rd_valid;
      if (fifo_rd_valid) begin
        out_data_nxt = fifo_rdata[PBO_SW-1:0];
        out_eol_nxt = fifo_rdata[PBO_SW];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
      out_eol_r <= 1'b0;
    end else begin
      out_valid_r <= out_valid_nxt;
      out_data_r <= out_data_nxt;
      out_eol_r <= out_eol_nxt;
    end
  end

  assign out_valid = out_valid_r;
  assign out_data = out_data_r;
  assign out_eol = out_eol_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence red_val_wr_s;
    reg_wr && reg_addr == PBO_REG_VAL && sel_r == PBO_SEL_RED;
  endsequence
  sequence mid_line_s;
    st_r == PBO_ST_LINE && !load;
  endsequence

  red_val_write_a: assert property (red_val_wr_s |=> bl_r[PBO_SEL_RED] == $past(reg_wdata))
    else $error("value write missed the selected red setting");
  shift_refuse_a: assert property (reg_wr && reg_addr == PBO_REG_SHIFT && reg_wdata > 8'h04
    |=> shift_r == $past(shift_r))
    else $error("illegal shift code was accepted");
  line_hold_a: assert property (mid_line_s |=> act_shift_r == $past(act_shift_r)
    && act_bl_r[PBO_SEL_ALL] == $past(act_bl_r[PBO_SEL_ALL]))
    else $error("settings changed inside a line");
  offset_sum_a: assert property (fire && !load && pix_tap == PBO_TAP_RED && pix_data < 12'h800
    |=> s1_data_r == $past(pix_data) + PBO_SW'($past(act_bl_r[PBO_SEL_ALL]))
    + PBO_SW'($past(act_bl_r[PBO_SEL_RED])))
    else $error("red pixel offset is not global plus red");
  clamp_full_a: assert property (fire && pix_data == PBO_FULL |=> s1_data_r == PBO_FULL)
    else $error("offset sum not clamped to full scale");
  pass_twelve_a: assert property (s1_valid_r && s1_fmt_r && s1_shift_r == 3'h0
    |-> shp_data == s1_data_r)
    else $error("12 bit unshifted sample altered");
  shift_two_a: assert property (s1_valid_r && s1_fmt_r && s1_shift_r == 3'h2 && s1_data_r[11:10] == 2'h0
    |-> shp_data == {s1_data_r[9:0], 2'h0})
    else $error("12 bit shift by two window wrong");
  sat_three_a: assert property (s1_valid_r && s1_fmt_r && s1_shift_r == 3'h3 && |s1_data_r[11:9]
    |-> shp_data == 12'hFFF)
    else $error("overflowed pixel not saturated");
  eight_window_a: assert property (s1_valid_r && !s1_fmt_r && s1_shift_r == 3'h1 && !s1_data_r[11]
    |-> shp_data == {4'h0, s1_data_r[10:3]})
    else $error("8 bit shift by one window wrong");
  read_pulse_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data stood outside its cycle");

endmodule : pbo_core

// >>> pbo_fifo.sv
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module pbo_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data,
  // occupancy
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  generate
    if (DEPTH < 2) begin : g_chk
      $error("pbo_fifo needs DEPTH of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [LW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH-1)) ? '0 : p + PW'(1);
  endfunction : bump

  assign wr_ready = (cnt_r != LW'(DEPTH));
  assign rd_valid = (cnt_r != '0);
  assign rd_data = mem_r[rp_r];
  assign level = cnt_r;
  assign push = wr_valid & wr_ready;
  assign pop = rd_valid & rd_ready;

  always_comb begin
    wp_nxt = push ? bump(wp_r) : wp_r;
    rp_nxt = pop ? bump(rp_r) : rp_r;
    cnt_nxt = cnt_r + LW'(push) - LW'(pop);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset; contents are only read once written
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wp_r] <= wr_data;
    end
  end

endmodule : pbo_fifo

// >>> pbo_pkg.sv
// constants, register map and types shared by the black level / shift pixel path
package pbo_pkg;

  localparam int PBO_SW = 12;
  localparam int PBO_BLW = 8;
  localparam int PBO_AW = 3;
  localparam int PBO_FIFO_DEPTH = 8;

  localparam logic [PBO_AW-1:0] PBO_REG_SEL = 3'h0;
  localparam logic [PBO_AW-1:0] PBO_REG_VAL = 3'h1;
  localparam logic [PBO_AW-1:0] PBO_REG_SHIFT = 3'h2;
  localparam logic [PBO_AW-1:0] PBO_REG_FMT = 3'h3;
  localparam logic [PBO_AW-1:0] PBO_REG_STAT = 3'h4;

  localparam int PBO_STAT_LINE = 0;
  localparam int PBO_STAT_SAT = 1;
  localparam int PBO_STAT_FULL = 2;

  localparam logic [PBO_BLW-1:0] PBO_BL_RST = 8'h00;
  localparam logic [2:0] PBO_SHIFT_RST = 3'h0;
  localparam logic [2:0] PBO_SHIFT_MAX = 3'h4;
  localparam logic PBO_FMT_RST = 1'b0;
  localparam logic [PBO_SW-1:0] PBO_FULL = 12'hFFF;

  typedef enum logic [1:0] {PBO_SEL_ALL, PBO_SEL_RED, PBO_SEL_GREEN, PBO_SEL_BLUE} pbo_sel_e;
  typedef enum logic [1:0] {PBO_TAP_RED, PBO_TAP_GREEN, PBO_TAP_BLUE} pbo_tap_e;
  typedef enum logic {PBO_ST_IDLE, PBO_ST_LINE} pbo_state_e;

endpackage : pbo_pkg

// >>> pbo_shift.sv
// bit-window selection with saturation for 12 and 8 bit output depth
`timescale 1ns/1ps
module pbo_shift
  import pbo_pkg::*;
(
  // sample and settings
  input wire logic [PBO_SW-1:0] sample,
  input wire logic [2:0] shift,
  input wire logic fmt12,
  // result, 8 bit depth sits in the low bits
  output logic [PBO_SW-1:0] result,
  output logic sat
);
  logic [PBO_SW+3:0] win;

  always_comb begin
    // the whole window moves down by shift in either depth
    win = {4'h0, sample} << shift;
    sat = |win[PBO_SW+3:PBO_SW];
    if (fmt12) begin
      result = sat ? PBO_FULL : win[PBO_SW-1:0];
    end else begin
      result = sat ? {4'h0, 8'hFF} : {4'h0, win[PBO_SW-1:4]};
    end
  end

endmodule : pbo_shift

// >>> pbo_sink_model.sv
// pixel sink model standing in for the downstream pixel formatter
`timescale 1ns/1ps
module pbo_sink_model
  import pbo_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pixel stream from the block
  input wire logic out_valid,
  input wire logic [PBO_SW-1:0] out_data,
  input wire logic out_eol,
  output logic out_ready,
  // pacing: 0 takes every beat, 1 takes one beat in four
  input wire logic slow
);
  logic [1:0] pace_r = 2'h0;
  logic [PBO_SW:0] got [$];
  // a slow sink is what lets the fifo fill up and push back on the input
  always @(posedge mclk) begin
    if (out_valid && out_ready && !rst) begin
      got.push_back({out_eol, out_data});
    end
    pace_r <= rst ? 2'h0 : pace_r + 2'h1;
    out_ready <= !rst && (!slow || pace_r == 2'h3);
  end
endmodule : pbo_sink_model

// >>> tb_top.sv
// self-checking bench for the black level and shift pixel path
`timescale 1ns/1ps
module tb_top;
  import pbo_pkg::*;
  typedef struct {logic [11:0] d; logic [1:0] tap; logic [2:0] sh; logic f12; logic [11:0] exp;} pbo_row_s;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [PBO_AW-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pix_valid = 1'b0;
  logic [PBO_SW-1:0] pix_data = '0;
  logic [1:0] pix_tap = 2'h0;
  logic pix_sol = 1'b0;
  logic pix_eol = 1'b0;
  logic pix_ready, out_valid, out_eol, out_ready;
  logic [PBO_SW-1:0] out_data;
  logic slow = 1'b0;
  int err_count = 0;
  int n_tests = 0;
  int stalls = 0;
  // offsets in use: global 16, red 1, green 2, blue 0, tap code 3 global only
  pbo_row_s rows [13] = '{
    '{12'h064, 2'h0, 3'h0, 1'b1, 12'h075}, '{12'h3E0, 2'h1, 3'h1, 1'b1, 12'h7E4},
    '{12'h100, 2'h2, 3'h2, 1'b1, 12'h440}, '{12'h0F0, 2'h3, 3'h3, 1'b1, 12'h800},
    '{12'h050, 2'h2, 3'h4, 1'b1, 12'h600}, '{12'h0EF, 2'h0, 3'h4, 1'b1, 12'hFFF},
    '{12'hFFF, 2'h0, 3'h0, 1'b1, 12'hFFF}, '{12'h100, 2'h2, 3'h0, 1'b0, 12'h011},
    '{12'h100, 2'h2, 3'h1, 1'b0, 12'h022}, '{12'h010, 2'h1, 3'h3, 1'b0, 12'h011},
    '{12'h00F, 2'h3, 3'h4, 1'b0, 12'h01F}, '{12'h3F0, 2'h2, 3'h2, 1'b0, 12'h0FF},
    '{12'h200, 2'h3, 3'h3, 1'b1, 12'hFFF}};

  always #10 mclk = ~mclk;

  pbo_core DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_valid(pix_valid), .pix_data(pix_data), .pix_tap(pix_tap),
    .pix_sol(pix_sol), .pix_eol(pix_eol), .pix_ready(pix_ready), .out_valid(out_valid), .out_data(out_data),
    .out_eol(out_eol), .out_ready(out_ready));
  pbo_sink_model SNK (.mclk(mclk), .rst(rst), .out_valid(out_valid), .out_data(out_data), .out_eol(out_eol),
    .out_ready(out_ready), .slow(slow));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [PBO_AW-1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [PBO_AW-1:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", {5'h00, exp}, {5'h00, reg_rdata});
  endtask : rd

  // entered just after an edge; leaves valid up so beats can run back to back
  task automatic send(input logic [11:0] d, input logic [1:0] tap, input logic sol, input logic eol);
    int i;
    pix_valid <= 1'b1;
    pix_data <= d;
    pix_tap <= tap;
    pix_sol <= sol;
    pix_eol <= eol;
    for (i = 0; i < 200; i++) begin
      @(posedge mclk);
      if (pix_ready === 1'b1) break;
      stalls++;
    end
    if (i == 200) begin
      err_count++;
      give_verdict();
    end
  endtask : send

  task automatic expect_pix(input logic eol, input logic [11:0] exp);
    int i;
    for (i = 0; i < 200 && SNK.got.size() == 0; i++) @(posedge mclk);
    if (i == 200) begin
      err_count++;
      give_verdict();
    end
    check("out_data", {eol, exp}, SNK.got.pop_front());
  endtask : expect_pix

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    // tap sums stay within 255
    wr(PBO_REG_SEL, 8'h01);
    wr(PBO_REG_VAL, 8'h01);
    wr(PBO_REG_SEL, 8'h02);
    wr(PBO_REG_VAL, 8'h02);
    wr(PBO_REG_SEL, 8'h00);
    wr(PBO_REG_VAL, 8'h10);
    foreach (rows[k]) begin
      wr(PBO_REG_SHIFT, {5'h00, rows[k].sh});
      wr(PBO_REG_FMT, {7'h00, rows[k].f12});
      send(rows[k].d, rows[k].tap, 1'b1, 1'b1);
      pix_valid <= 1'b0;
      expect_pix(1'b1, rows[k].exp);
    end
    // saturating rows leave the sticky flag up; the read clears it
    rd(PBO_REG_STAT, 8'h02);
    rd(PBO_REG_STAT, 8'h00);
    $display("test table done");
    // a global change in mid-line waits for the next line start
    wr(PBO_REG_SHIFT, 8'h00);
    wr(PBO_REG_FMT, 8'h00);
    send(12'h100, 2'h3, 1'b1, 1'b0);
    pix_valid <= 1'b0;
    rd(PBO_REG_STAT, 8'h01);
    wr(PBO_REG_VAL, 8'h20);
    send(12'h100, 2'h0, 1'b0, 1'b1);
    send(12'h100, 2'h3, 1'b1, 1'b1);
    pix_valid <= 1'b0;
    expect_pix(1'b0, 12'h011);
    expect_pix(1'b1, 12'h011);
    expect_pix(1'b1, 12'h012);
    $display("test line latch done");
    // slow sink fills the fifo until the input stalls, then everything drains in order
    wr(PBO_REG_FMT, 8'h01);
    wr(PBO_REG_VAL, 8'h00);
    slow <= 1'b1;
    stalls = 0;
    for (int i = 0; i < 14; i++) send(12'(i * 291), 2'h3, i == 0, i == 13);
    pix_valid <= 1'b0;
    for (int i = 0; i < 14; i++) expect_pix(i == 13, 12'(i * 291));
    check("pix_ready stall", 13'h0001, {12'h000, stalls != 0});
    slow <= 1'b0;
    $display("test backpressure done");
    // selector routes the value port; shift codes above 4 are ignored
    wr(PBO_REG_SEL, 8'h02);
    rd(PBO_REG_SEL, 8'h02);
    rd(PBO_REG_VAL, 8'h02);
    wr(PBO_REG_VAL, 8'hFF);
    rd(PBO_REG_VAL, 8'hFF);
    wr(PBO_REG_SEL, 8'h01);
    rd(PBO_REG_VAL, 8'h01);
    wr(PBO_REG_SHIFT, 8'h03);
    wr(PBO_REG_SHIFT, 8'h05);
    rd(PBO_REG_SHIFT, 8'h03);
    rd(3'h5, 8'h00);
    rd(3'h7, 8'h00);
    $display("test registers done");
    // second reset in mid-run clears every setting
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    check("out_valid", 13'h0000, {12'h000, out_valid});
    check("pix_ready", 13'h0000, {12'h000, pix_ready});
    @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++) rd(a[PBO_AW-1:0], 8'h00);
    $display("test reset done");
    give_verdict();
  end
endmodule : tb_top
